// File: pkg/rhs_defines.svh
// Offsets, field positions, reset values and timing counts of the hop sequencer.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
`ifndef RHS_DEFINES_SVH
`define RHS_DEFINES_SVH
// ==========================================
// Register byte offsets
`define RHS_OFF_CMD       6'h00
`define RHS_OFF_INTEGER   6'h04
`define RHS_OFF_FRACTION  6'h08
`define RHS_OFF_STEP_LO   6'h0c
`define RHS_OFF_STEP_HI   6'h10
`define RHS_OFF_BAND      6'h14
`define RHS_OFF_HOP_CTRL  6'h18
`define RHS_OFF_TBL_SIZE  6'h1c
`define RHS_OFF_THRESH    6'h20
`define RHS_OFF_TBL_ENTRY 6'h24
`define RHS_OFF_CAL_COUNT 6'h28
`define RHS_OFF_STATUS    6'h2c
`define RHS_OFF_FREQ      6'h30
// ==========================================
// Field positions and constants
`define RHS_CMD_HAS_CH    8
`define RHS_CMD_RX        9
`define RHS_CMD_TX        10
`define RHS_CMD_HOP       11
`define RHS_CMD_STOP      12
`define RHS_FRAC_BITS     19
`define RHS_UNUSED_ENTRY  8'hff
`define RHS_TBL_MAX       7'h40
`define RHS_FRAC_RESET    20'h80000
`define RHS_REF_HZ        30000000
// ==========================================
// Timing: full calibration, RSSI settle, clock period
`define RHS_CLK_NS        40
`define RHS_CAL_NS        60000
`define RHS_CAL_CYC       ((`RHS_CAL_NS + `RHS_CLK_NS - 1) / `RHS_CLK_NS)
`define RHS_SETTLE_NS     4000
`define RHS_SETTLE_CYC    ((`RHS_SETTLE_NS + `RHS_CLK_NS - 1) / `RHS_CLK_NS)
`endif

// File: pkg/rhs_pkg.sv
// Types shared by the hop sequencer.
// Assumes rhs_defines.svh for the numbers.
package rhs_pkg;
    // ==========================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CAL    = 3'b001,
        ST_LISTEN = 3'b010,
        ST_STAY   = 3'b011,
        ST_SEARCH = 3'b100,
        ST_TX     = 3'b101
    } rhs_state_t;
    // ==========================================
    // Hop control fields
    typedef struct packed {
        logic gpioWrap;
        logic gpioHop;
        logic pktEn;
        logic syncEn;
        logic preambleEn;
        logic rssiEn;
        logic hopEn;
    } rhs_hop_ctrl_t;
    // ==========================================
    // Packet-handler events from the modem
    typedef struct packed {
        logic preambleValid;
        logic preambleTimeout;
        logic syncOk;
        logic syncTimeout;
    } rhs_pkt_evt_t;
endpackage

// File: design/rhs_hop_sequencer.sv
// Frequency control and automatic receive hopping, Avalon-MM register slave.
// Assumes modem inputs synchronous to ref_clk; one clock domain.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rhs_defines.svh"
module rhs_hop_sequencer #(
    parameter int TBL_DEPTH  = 64,
    parameter int REF_HZ     = `RHS_REF_HZ,
    parameter int CAL_CYC    = `RHS_CAL_CYC,
    parameter int SETTLE_CYC = `RHS_SETTLE_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 clkEn,
    input  wire logic [5:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    input  wire logic [7:0]           rssi,
    input  wire rhs_pkg::rhs_pkt_evt_t pktEvt,
    output logic      [27:0]          synthWord,
    output logic      [4:0]           outDiv,
    output logic      [31:0]          rfFreqHz,
    output logic      [7:0]           channel,
    output logic                      rxOn,
    output logic                      txOn,
    output logic                      calSkip,
    output logic      [15:0]          calCountOut,
    output logic                      hopGpio
);
    // ==========================================
    // Helper functions
    // Band code to output divider
    function automatic logic [4:0] band_div(input logic [2:0] band);
        case (band)
            3'h0:    band_div = 5'h18;
            3'h1:    band_div = 5'h0c;
            3'h2:    band_div = 5'h0a;
            3'h3:    band_div = 5'h08;
            default: band_div = 5'h04;
        endcase
    endfunction
    // Tuning word to output frequency in Hz
    function automatic logic [31:0] word_hz(input logic [28:0] w, input logic [4:0] d);
        logic [63:0] p;
        p = 64'(w) * 64'(2 * REF_HZ) / 64'(d);
        word_hz = p[`RHS_FRAC_BITS +: 32];
    endfunction

    // ==========================================
    // Registers
    logic [7:0]             integerWord;
    logic [19:0]            fractionWord;
    logic [7:0]             stepLo;
    logic [7:0]             stepHi;
    logic [2:0]             band;
    rhs_pkg::rhs_hop_ctrl_t hopCtrl;
    logic [6:0]             tblSize;
    logic [7:0]             signalLevelThreshold;
    logic [15:0]            oscillatorCalCount;
    logic [7:0]             hopTable [TBL_DEPTH];
    logic [7:0]             storedChannel;
    rhs_pkg::rhs_state_t    state;
    logic [5:0]             hopIdx;
    logic [6:0]             searchCnt;
    logic [15:0]            waitCnt;
    logic                   goTx;

    // ==========================================
    // Bus decode: answer at the second edge of a request
    wire        busReq   = read | write;
    wire        busTake  = busReq & ~waitrequest;
    wire        wrTake   = busTake & write;
    wire        wrCmd    = wrTake & (address == `RHS_OFF_CMD);
    wire        cmdHasCh = writedata[`RHS_CMD_HAS_CH];
    wire        cmdRx    = wrCmd & writedata[`RHS_CMD_RX];
    wire        cmdTx    = wrCmd & writedata[`RHS_CMD_TX] & ~writedata[`RHS_CMD_RX];
    wire        cmdHop   = wrCmd & writedata[`RHS_CMD_HOP];
    wire        cmdStop  = wrCmd & writedata[`RHS_CMD_STOP];
    wire [7:0]  startCh  = cmdHasCh ? writedata[7:0] : storedChannel;
    wire [31:0] statusWord = {13'h0, state, 2'h0, hopIdx, storedChannel};
    logic [31:0] rdMux;
    always_comb begin
        case (address)
            `RHS_OFF_INTEGER:   rdMux = {24'h0, integerWord};
            `RHS_OFF_FRACTION:  rdMux = {12'h0, fractionWord};
            `RHS_OFF_STEP_LO:   rdMux = {24'h0, stepLo};
            `RHS_OFF_STEP_HI:   rdMux = {24'h0, stepHi};
            `RHS_OFF_BAND:      rdMux = {29'h0, band};
            `RHS_OFF_HOP_CTRL:  rdMux = {25'h0, hopCtrl};
            `RHS_OFF_TBL_SIZE:  rdMux = {25'h0, tblSize};
            `RHS_OFF_THRESH:    rdMux = {24'h0, signalLevelThreshold};
            `RHS_OFF_CAL_COUNT: rdMux = {16'h0, oscillatorCalCount};
            `RHS_OFF_STATUS:    rdMux = statusWord;
            `RHS_OFF_FREQ:      rdMux = rfFreqHz;
            default:            rdMux = 32'h0;
        endcase
    end

    // ==========================================
    // Frequency arithmetic
    wire [27:0] baseWord  = {integerWord, 19'h0} + 28'(fractionWord);
    wire [15:0] stepSize  = {stepHi, stepLo};
    wire [28:0] chanWord  = 29'(baseWord) + 29'(channel * stepSize);
    wire [4:0]  divNext   = band_div(band);

    // ==========================================
    // Hop decision and table walk
    wire [7:0]  curEntry   = hopTable[hopIdx];
    wire        entryUsed  = curEntry != `RHS_UNUSED_ENTRY;
    wire        lastEntry  = 7'(hopIdx) + 7'h1 >= tblSize;
    wire [5:0]  nextIdx    = lastEntry ? 6'h0 : hopIdx + 6'h1;
    wire        settled    = waitCnt == 16'h0;
    wire        pktOk      = hopCtrl.pktEn;
    wire        rssiHigh   = rssi > signalLevelThreshold;
    wire        stayRssi   = hopCtrl.rssiEn & settled & rssiHigh;
    wire        hopRssi    = hopCtrl.rssiEn & settled & ~rssiHigh;
    wire        stayPkt    = pktOk & ((hopCtrl.preambleEn & pktEvt.preambleValid)
                                    | (hopCtrl.syncEn & pktEvt.syncOk));
    wire        hopPkt     = pktOk & ((hopCtrl.preambleEn & pktEvt.preambleTimeout)
                                    | (hopCtrl.syncEn & pktEvt.syncTimeout));
    wire        decideStay = stayRssi | stayPkt;
    wire        decideHop  = (hopRssi | hopPkt) & ~decideStay;
    wire        autoHop    = state == rhs_pkg::ST_LISTEN & hopCtrl.hopEn & decideHop;
    wire        tblEmpty   = searchCnt >= tblSize;

    // ==========================================
    // Bus handshake and read data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end else if (clkEn) begin
            waitrequest <= ~(busReq & waitrequest);
            if (busReq & waitrequest) begin
                readdata <= read ? rdMux : 32'h0;
            end
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            integerWord          <= 8'h0;
            fractionWord         <= `RHS_FRAC_RESET;
            stepLo               <= 8'h0;
            stepHi               <= 8'h0;
            band                 <= 3'h0;
            hopCtrl              <= '0;
            tblSize              <= 7'h0;
            signalLevelThreshold <= 8'h0;
            oscillatorCalCount   <= 16'h0;
        end else if (clkEn & wrTake) begin
            case (address)
                `RHS_OFF_INTEGER:   integerWord          <= writedata[7:0];
                `RHS_OFF_FRACTION:  fractionWord         <= writedata[19:0];
                `RHS_OFF_STEP_LO:   stepLo               <= writedata[7:0];
                `RHS_OFF_STEP_HI:   stepHi               <= writedata[7:0];
                `RHS_OFF_BAND:      band                 <= writedata[2:0];
                `RHS_OFF_HOP_CTRL:  hopCtrl              <= writedata[6:0];
                `RHS_OFF_TBL_SIZE:  tblSize              <= (writedata[6:0] > `RHS_TBL_MAX) ?
                                                            `RHS_TBL_MAX : writedata[6:0];
                `RHS_OFF_THRESH:    signalLevelThreshold <= writedata[7:0];
                `RHS_OFF_CAL_COUNT: oscillatorCalCount   <= writedata[15:0];
                default:            ;
            endcase
        end
    end

    // Hop table storage, written as index and entry in one word
    always_ff @(posedge ref_clk) begin
        if (clkEn & wrTake & (address == `RHS_OFF_TBL_ENTRY)) begin
            hopTable[writedata[13:8]] <= writedata[7:0];
        end
    end

    // ==========================================
    // Sequencer state machine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state         <= rhs_pkg::ST_IDLE;
            storedChannel <= 8'h0;
            channel       <= 8'h0;
            hopIdx        <= 6'h0;
            searchCnt     <= 7'h0;
            waitCnt       <= 16'h0;
            goTx          <= 1'b0;
            calSkip       <= 1'b0;
            hopGpio       <= 1'b0;
        end else if (clkEn) begin
            if (cmdStop) begin
                state <= rhs_pkg::ST_IDLE;
            end else if (cmdRx | cmdTx) begin
                storedChannel <= startCh;
                channel       <= startCh;
                goTx          <= cmdTx;
                calSkip       <= 1'b0;
                waitCnt       <= 16'(CAL_CYC);
                hopIdx        <= 6'h0;
                state         <= rhs_pkg::ST_CAL;
            end else if (cmdHop) begin
                storedChannel <= startCh;
                channel       <= startCh;
                goTx          <= 1'b0;
                calSkip       <= 1'b1;
                waitCnt       <= 16'h1;
                state         <= rhs_pkg::ST_CAL;
            end else begin
                case (state)
                    rhs_pkg::ST_CAL: begin
                        if (waitCnt > 16'h1) begin
                            waitCnt <= waitCnt - 16'h1;
                        end else begin
                            waitCnt <= 16'(SETTLE_CYC);
                            state   <= goTx ? rhs_pkg::ST_TX : rhs_pkg::ST_LISTEN;
                        end
                    end
                    rhs_pkg::ST_LISTEN: begin
                        if (!settled) begin
                            waitCnt <= waitCnt - 16'h1;
                        end
                        if (hopCtrl.hopEn & decideStay) begin
                            state <= rhs_pkg::ST_STAY;
                        end else if (autoHop) begin
                            hopIdx    <= nextIdx;
                            searchCnt <= 7'h1;
                            state     <= rhs_pkg::ST_SEARCH;
                            if (lastEntry & hopCtrl.gpioWrap) begin
                                hopGpio <= ~hopGpio;
                            end
                        end
                    end
                    rhs_pkg::ST_SEARCH: begin
                        if (entryUsed) begin
                            channel       <= curEntry;
                            storedChannel <= curEntry;
                            calSkip       <= 1'b1;
                            waitCnt       <= 16'h1;
                            state         <= rhs_pkg::ST_CAL;
                            if (hopCtrl.gpioHop) begin
                                hopGpio <= ~hopGpio;
                            end
                        end else if (tblEmpty) begin
                            state <= rhs_pkg::ST_STAY;
                        end else begin
                            hopIdx    <= nextIdx;
                            searchCnt <= searchCnt + 7'h1;
                            if (lastEntry & hopCtrl.gpioWrap) begin
                                hopGpio <= ~hopGpio;
                            end
                        end
                    end
                    rhs_pkg::ST_IDLE,
                    rhs_pkg::ST_STAY,
                    rhs_pkg::ST_TX: ;
                    default: state <= rhs_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // Registered synthesizer outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            synthWord   <= 28'h0;
            outDiv      <= 5'h18;
            rfFreqHz    <= 32'h0;
            rxOn        <= 1'b0;
            txOn        <= 1'b0;
            calCountOut <= 16'h0;
        end else if (clkEn) begin
            synthWord   <= chanWord[27:0];
            outDiv      <= divNext;
            rfFreqHz    <= word_hz(chanWord, divNext);
            rxOn        <= state == rhs_pkg::ST_LISTEN | state == rhs_pkg::ST_STAY
                         | state == rhs_pkg::ST_SEARCH;
            txOn        <= state == rhs_pkg::ST_TX;
            calCountOut <= oscillatorCalCount;
        end
    end
endmodule

// File: verification/rhs_hop_sequencer_properties.sv
// Port-level assertions for the hop sequencer, bound into its top module.
// Assumes one clock domain and bus requests held until waitrequest is low.
`timescale 1ns/1ps
`include "rhs_defines.svh"
module rhs_seq_checker #(
    parameter int REF_HZ  = 30000000,
    parameter int CAL_CYC = 4
) (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        clkEn,
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    input wire logic [27:0] synthWord,
    input wire logic [4:0]  outDiv,
    input wire logic [31:0] rfFreqHz,
    input wire logic [7:0]  channel,
    input wire logic        rxOn,
    input wire logic        txOn,
    input wire logic        calSkip,
    input wire logic        hopGpio
);
    // ==========================================
    // Decode of accepted writes
    localparam int CAL_MAX = CAL_CYC + 8;
    logic [31:0] cmdWord;
    logic [2:0]  bandCode;
    logic [31:0] freqExp;
    logic [4:0]  divExp;
    wire         cmdDone = write && !waitrequest && address == `RHS_OFF_CMD;
    wire         startOk = (writedata[`RHS_CMD_RX] || writedata[`RHS_CMD_TX]) && !writedata[`RHS_CMD_STOP];
    assign divExp = bandCode == 3'h0 ? 5'h18 : bandCode == 3'h1 ? 5'h0c :
                    bandCode == 3'h2 ? 5'h0a : bandCode == 3'h3 ? 5'h08 : 5'h04;
    // Frequency from the word and divider standing in the same cycle
    assign freqExp = 32'((64'(synthWord) * 64'h2 * 64'(REF_HZ) / 64'(outDiv)) >> 19);
    // Last command, last band code
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdWord  <= 32'h0;
            bandCode <= 3'h0;
        end else if (clkEn) begin
            if (cmdDone) cmdWord <= writedata;
            if (write && !waitrequest && address == `RHS_OFF_BAND) bandCode <= writedata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // Assertions
    chk_wait_take:
        assert property ((read || write) && waitrequest && clkEn |=> !waitrequest) else $error("request not answered");
    chk_wait_pulse:
        assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
    chk_div_legal:
        assert property (outDiv inside {5'h18, 5'h0c, 5'h0a, 5'h08, 5'h04}) else $error("illegal divider");
    chk_div_band:
        assert property (write && !waitrequest && address == `RHS_OFF_BAND |=> ##[0:1] outDiv == divExp)
            else $error("divider does not follow band");
    chk_freq_calc:
        assert property (rfFreqHz == freqExp) else $error("frequency result wrong");
    chk_stop_idle:
        assert property (cmdDone && writedata[`RHS_CMD_STOP] |=> ##[0:2] !rxOn && !txOn) else $error("stop ignored");
    chk_rx_start:
        assert property (cmdDone && startOk && writedata[`RHS_CMD_RX] |=> ##[0:CAL_MAX] rxOn)
            else $error("receive not entered");
    chk_channel_arg:
        assert property (cmdDone && startOk && writedata[`RHS_CMD_HAS_CH] |=> ##[0:CAL_MAX] channel == cmdWord[7:0])
            else $error("channel argument not used");
    chk_start_cal:
        assert property (cmdDone && startOk |=> ##[0:CAL_MAX] !calSkip) else $error("start kept host calibration");
    chk_rxtx_excl:
        assert property (!(rxOn && txOn)) else $error("receive and transmit together");
    // Main scenarios reached
    cov_manual: cover property (cmdDone && writedata[`RHS_CMD_HOP]);
    cov_gpio: cover property ($changed(hopGpio));
    cov_autohop: cover property (calSkip && rxOn);
endmodule
bind rhs_hop_sequencer rhs_seq_checker #(.REF_HZ(REF_HZ), .CAL_CYC(CAL_CYC)) i_rhs_seq_checker (
    .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .address(address), .read(read), .write(write),
    .writedata(writedata), .waitrequest(waitrequest), .synthWord(synthWord), .outDiv(outDiv),
    .rfFreqHz(rfFreqHz), .channel(channel), .rxOn(rxOn), .txOn(txOn), .calSkip(calSkip), .hopGpio(hopGpio)
);

// File: verification/rhs_host_model.sv
// Host microcontroller model: Avalon-MM master issuing settings and commands.
// Assumes callers run one transfer at a time from the testbench.
`timescale 1ns/1ps
module rhs_host_model (
    input  wire logic        ref_clk,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    output logic      [5:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata
);
    // ==========================================
    // Idle bus at time zero
    initial begin
        address   = 6'h00;
        read      = 1'b0;
        write     = 1'b0;
        writedata = 32'h0;
    end
    // One transfer, held until waitrequest is sampled low; data inverted after
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do
            @(posedge ref_clk);
        while (waitrequest !== 1'b0);
        q = readdata;
        write     <= 1'b0;
        read      <= 1'b0;
        writedata <= ~d;
    endtask
    // Settings go out one write per call, in the caller's order
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
endmodule

// File: verification/rhs_hop_sequencer_test.sv
// Self-checking bench: reset values, tuning, auto and manual hopping.
// Assumes rhs_host_model as bus master and the bound port checker.
`timescale 1ns/1ps
`include "rhs_defines.svh"
module rhs_hop_sequencer_test;
    // ==========================================
    // Constants and signals
    localparam logic [31:0] CH   = 32'h1 << `RHS_CMD_HAS_CH;
    localparam logic [31:0] RX   = 32'h1 << `RHS_CMD_RX;
    localparam logic [31:0] TX   = 32'h1 << `RHS_CMD_TX;
    localparam logic [31:0] HOP  = 32'h1 << `RHS_CMD_HOP;
    localparam logic [31:0] STOP = 32'h1 << `RHS_CMD_STOP;
    localparam logic [27:0] BASE = 28'h1e00000;
    localparam logic [27:0] STEP = 28'h123;
    localparam logic [4:0]  DIVS [5] = '{5'h18, 5'h0c, 5'h0a, 5'h08, 5'h04};
    localparam logic [7:0]  TBL  [4] = '{8'h02, 8'hff, 8'h07, 8'hff};
    localparam logic [31:0] CTL  [4] = '{32'h05, 32'h15, 32'h19, 32'h1d};
    localparam logic [3:0]  EVS  [4] = '{4'b0100, 4'b0100, 4'b0001, 4'b1001};
    localparam logic [7:0]  WANT [4] = '{8'h02, 8'h07, 8'h07, 8'h02};
    logic                  ref_clk = 1'b0;
    logic                  rst_b, clkEn, read, write, waitrequest, rxOn, txOn, calSkip, hopGpio;
    logic [5:0]            address;
    logic [31:0]           writedata, readdata, rfFreqHz;
    logic [7:0]            rssi, channel;
    logic [27:0]           synthWord;
    logic [4:0]            outDiv;
    logic [15:0]           calCountOut;
    rhs_pkg::rhs_pkt_evt_t pktEvt;
    int                    errTotal = 0;
    int                    samplesChecked = 0;
    // Clock and units under test
    always #20 ref_clk = ~ref_clk;
    rhs_hop_sequencer #(.CAL_CYC(4), .SETTLE_CYC(2)) i_rhs_hop_sequencer (
        .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .rssi(rssi), .pktEvt(pktEvt),
        .synthWord(synthWord), .outDiv(outDiv), .rfFreqHz(rfFreqHz), .channel(channel), .rxOn(rxOn),
        .txOn(txOn), .calSkip(calSkip), .calCountOut(calCountOut), .hopGpio(hopGpio));
    rhs_host_model i_rhs_host_model (.ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata));
    // ==========================================
    // Shared helpers
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        i_rhs_host_model.wr(a, d);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        i_rhs_host_model.rd(a, q);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] freqOf(input logic [27:0] sw, input logic [4:0] dv);
        return 32'((64'(sw) * 64'h2 * 64'h1c9c380 / 64'(dv)) >> 19);
    endfunction
    task automatic waitState(input logic [2:0] st);
        logic [31:0] q;
        q = 32'h0;
        for (int n = 0; n < 60 && q[18:16] !== st; n++) rd(`RHS_OFF_STATUS, q);
        chk("state", 32'(st), 32'(q[18:16]));
    endtask
    task automatic waitCh(input logic [7:0] c);
        for (int n = 0; n < 100 && channel !== c; n++) @(posedge ref_clk);
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic resetTest();
        logic [31:0] q;
        chk("outDiv", 32'h18, 32'(outDiv));
        chk("channel", 32'h0, 32'(channel));
        rd(`RHS_OFF_FRACTION, q);
        chk("fraction", 32'h80000, q);
        wr(`RHS_OFF_STATUS, 32'hffff);
        rd(`RHS_OFF_STATUS, q);
        chk("status", 32'h0, q);
        rd(6'h3c, q);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic freqTest();
        wr(`RHS_OFF_INTEGER, 32'h3b);
        wr(`RHS_OFF_FRACTION, 32'h80000);
        wr(`RHS_OFF_STEP_LO, 32'h23);
        wr(`RHS_OFF_STEP_HI, 32'h01);
        wr(`RHS_OFF_HOP_CTRL, 32'h0);
        wr(`RHS_OFF_CMD, CH | RX | 32'h5);
        waitState(3'h2);
        chk("synthWord", 32'(BASE + 28'h5 * STEP), 32'(synthWord));
        for (int b = 0; b < 5; b++) begin
            wr(`RHS_OFF_BAND, 32'(b));
            repeat (3) @(posedge ref_clk);
            chk("outDiv", 32'(DIVS[b]), 32'(outDiv));
            chk("rfFreqHz", freqOf(BASE + 28'h5 * STEP, DIVS[b]), rfFreqHz);
        end
        wr(`RHS_OFF_CMD, STOP);
        wr(`RHS_OFF_CMD, RX);
        waitState(3'h2);
        chk("kept channel", 32'h5, 32'(channel));
        wr(`RHS_OFF_CMD, CH | TX);
        waitState(3'h5);
        chk("txOn", 32'h1, 32'(txOn));
        chk("base word", 32'(BASE), 32'(synthWord));
        wr(`RHS_OFF_CMD, STOP);
    endtask
    task automatic hopTest();
        int chg;
        int tog;
        logic [7:0] prev;
        logic g;
        chg = 0;
        tog = 0;
        wr(`RHS_OFF_TBL_SIZE, 32'h4);
        for (int i = 0; i < 4; i++) wr(`RHS_OFF_TBL_ENTRY, {18'h0, 6'(i), TBL[i]});
        wr(`RHS_OFF_THRESH, 32'h80);
        wr(`RHS_OFF_HOP_CTRL, 32'h63);
        rssi <= 8'h10;
        wr(`RHS_OFF_CMD, CH | RX | 32'h2);
        waitCh(8'h02);
        prev = channel;
        g = hopGpio;
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            tog += int'(hopGpio !== g);
            g = hopGpio;
            if (channel !== prev) begin
                chk("hop channel", prev == 8'h02 ? 32'h7 : 32'h2, 32'(channel));
                chg++;
                prev = channel;
            end
            if (chg == 4) rssi <= 8'hf0;
        end
        chk("hops seen", 32'h1, 32'(chg >= 4));
        chk("gpio toggles", 32'(chg + chg / 2), 32'(tog));
        chk("calSkip", 32'h1, 32'(calSkip));
        waitState(3'h3);
    endtask
    task automatic pktTest();
        for (int k = 0; k < 4; k++) begin
            wr(`RHS_OFF_HOP_CTRL, CTL[k]);
            wr(`RHS_OFF_CMD, CH | RX | 32'h2);
            waitState(3'h2);
            pktEvt <= EVS[k];
            @(posedge ref_clk);
            pktEvt <= '0;
            repeat (20) @(posedge ref_clk);
            chk("event hop", 32'(WANT[k]), 32'(channel));
        end
    endtask
    task automatic emptyTest();
        wr(`RHS_OFF_TBL_SIZE, 32'h2);
        wr(`RHS_OFF_TBL_ENTRY, 32'h0ff);
        wr(`RHS_OFF_TBL_ENTRY, 32'h1ff);
        wr(`RHS_OFF_HOP_CTRL, 32'h03);
        rssi <= 8'h10;
        wr(`RHS_OFF_CMD, CH | RX | 32'h4);
        repeat (40) @(posedge ref_clk);
        waitState(3'h3);
        chk("kept channel", 32'h4, 32'(channel));
    endtask
    task automatic manualTest();
        wr(`RHS_OFF_HOP_CTRL, 32'h0);
        wr(`RHS_OFF_CAL_COUNT, 32'h1234);
        wr(`RHS_OFF_CMD, CH | HOP | 32'h9);
        repeat (10) @(posedge ref_clk);
        chk("calSkip", 32'h1, 32'(calSkip));
        chk("calCountOut", 32'h1234, 32'(calCountOut));
        chk("manual channel", 32'h9, 32'(channel));
        wr(`RHS_OFF_CMD, STOP);
        repeat (2) @(posedge ref_clk);
        chk("rxOn", 32'h0, 32'(rxOn));
    endtask
    // Main sequence
    initial begin
        rst_b  = 1'b0;
        clkEn  = 1'b1;
        rssi   = 8'h00;
        pktEvt = '0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        resetTest();
        freqTest();
        hopTest();
        pktTest();
        emptyTest();
        manualTest();
        giveVerdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        errTotal++;
        giveVerdict();
    end
endmodule
